// ==== rtl/uart_de_pkg.sv ====
// Constants and behaviour summary for the UART line driver enable control
// Behaviour
// RQ1: Without flow control, data write raises enable
// RQ2: Enable held across back-to-back written characters
// RQ3: Enable drops at stop end when empty
// RQ4: Flow control: enable 2 clocks to 2+bit after
// RQ5: Start bit 1 clock to 1 bit after enable
// RQ6: Software loads data before clear-to-send asserts
// RQ7: Bit time from baud divisor in clocks
package uart_de_pkg;
	localparam int CLOCK_HZ = 50000000;
	localparam int DIVISOR_WIDTH = 16;
	localparam int DATA_WIDTH = 8;
	localparam logic [DIVISOR_WIDTH-1:0] DIVISOR_DEFAULT = 16'h01b2;
	localparam logic [DIVISOR_WIDTH-1:0] DIVISOR_MIN = 16'h0002;
	localparam int STOP_BITS_MAX = 2;
	// Frame bits including data: start, eight data, one or two stop
	localparam logic [3:0] FRAME_BITS_ONE_STOP = 4'ha;
	localparam logic [3:0] FRAME_BITS_TWO_STOP = 4'hb;
	// Lead from enable to start bit, in clocks, at least one
	localparam logic [1:0] ENABLE_LEAD_CYCLES = 2'h1;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_SEND = 2'b10
	} tx_state_e;
endpackage

// ==== rtl/bit_timer.sv ====
// Baud tick generator counting system clocks per bit
`timescale 1ns/1ns
`default_nettype none
module bit_timer
	import uart_de_pkg::*;
#(
	parameter int WIDTH = DIVISOR_WIDTH
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic restart,
	input wire logic [WIDTH-1:0] divisor,
	output logic tick
);
	logic [WIDTH-1:0] count;
	wire logic [WIDTH-1:0] lastCount = (divisor < DIVISOR_MIN) ? WIDTH'(DIVISOR_MIN - 1'b1) : WIDTH'(divisor - 1'b1);
	wire logic atEnd = (count >= lastCount);

	// RQ7: bit period from divisor
	always_ff @(posedge clock) begin
		if (reset || restart || atEnd) begin
			count <= '0;
		end else begin
			count <= WIDTH'(count + 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset || restart) begin
			tick <= 1'b0;
		end else begin
			tick <= atEnd;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/uart_driver_enable_control.sv ====
// UART transmitter with line driver enable around each frame
`timescale 1ns/1ns
`default_nettype none
module uart_driver_enable_control
	import uart_de_pkg::*;
#(
	parameter int WIDTH = DATA_WIDTH,
	parameter int DIV_WIDTH = DIVISOR_WIDTH
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [DIV_WIDTH-1:0] divisor,
	input wire logic flowControl,
	input wire logic twoStopBits,
	input wire logic clearToSendN,
	input wire logic dataWrite,
	input wire logic [WIDTH-1:0] writeData,
	output logic dataPending,
	output logic line_driver_enable,
	output logic txd,
	output logic busy
);
	tx_state_e state;
	tx_state_e next_state;
	logic [WIDTH-1:0] holdData;
	logic [WIDTH+1:0] shifter;
	logic [3:0] bitsLeft;
	logic [2:0] ctsSync;
	logic ctsLow;
	logic restartTimer;
	wire logic tick;

	// Clear-to-send pin: three flops, change taken when last two agree
	always_ff @(posedge clock) begin
		if (reset) begin
			ctsSync <= 3'h7;
			ctsLow <= 1'b0;
		end else begin
			ctsSync <= {ctsSync[1:0], clearToSendN};
			if (ctsSync[1] == ctsSync[2]) begin
				ctsLow <= ~ctsSync[2];
			end
		end
	end

	wire logic sendAllowed = ~flowControl | ctsLow;
	wire logic loadNow = dataPending && sendAllowed;
	wire logic lastBit = tick && (bitsLeft == 4'h1);
	wire logic frameDone = (state == ST_SEND) && lastBit;
	wire logic [3:0] frameBits = twoStopBits ? FRAME_BITS_TWO_STOP : FRAME_BITS_ONE_STOP;

	bit_timer #(
		.WIDTH(DIV_WIDTH)
	) timer (
		.clock(clock),
		.reset(reset),
		.restart(restartTimer),
		.divisor(divisor),
		.tick(tick)
	);

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// RQ1: pending data starts enable; RQ4: gated by clear-to-send
				if (loadNow) begin
					next_state = ST_LEAD;
				end
			end
			ST_LEAD: begin
				// RQ5: start bit one clock after enable
				next_state = ST_SEND;
			end
			ST_SEND: begin
				// RQ2: next char chains on; RQ3: else back to idle
				if (frameDone) begin
					next_state = loadNow ? ST_LEAD : ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Holding register; a write during a take still lands as pending
	always_ff @(posedge clock) begin
		if (reset) begin
			holdData <= '0;
			dataPending <= 1'b0;
		end else if (dataWrite) begin
			holdData <= writeData;
			dataPending <= 1'b1;
		end else if (next_state == ST_LEAD && state != ST_LEAD) begin
			dataPending <= 1'b0;
		end
	end

	assign restartTimer = (next_state == ST_LEAD);

	always_ff @(posedge clock) begin
		if (reset) begin
			shifter <= '1;
			bitsLeft <= '0;
		end else if (state != ST_LEAD && next_state == ST_LEAD) begin
			shifter <= {1'b1, holdData, 1'b0};
			bitsLeft <= frameBits;
		end else if (state == ST_SEND && tick) begin
			shifter <= {1'b1, shifter[WIDTH+1:1]};
			bitsLeft <= 4'(bitsLeft - 1'b1);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			txd <= 1'b1;
			line_driver_enable <= 1'b0;
			busy <= 1'b0;
		end else begin
			// RQ3: enable falls at the end of the last stop bit
			line_driver_enable <= (next_state != ST_IDLE);
			busy <= (next_state != ST_IDLE);
			txd <= (next_state == ST_SEND) ? ((state == ST_LEAD) ? 1'b0 : next_shift0()) : 1'b1;
		end
	end

	function automatic logic next_shift0();
		if (state == ST_SEND && tick) begin
			return (bitsLeft == 4'h1) ? 1'b1 : shifter[1];
		end
		return shifter[0];
	endfunction
endmodule
`default_nettype wire

// ==== sim/uart_de_monitor.sv ====
// Driver enable timing checker
`timescale 1ns/1ns
`default_nettype none
module uart_de_monitor(
	input wire logic clock,
	input wire logic reset,
	input wire logic flowControl,
	input wire logic clearToSendN,
	input wire logic dataPending,
	input wire logic line_driver_enable,
	input wire logic txd,
	input wire logic busy
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	property p_h; line_driver_enable && dataPending && !flowControl |=> line_driver_enable; endproperty
	a_h: assert property (p_h) else $error("gap");
	property p_d; $fell(line_driver_enable) && !flowControl |-> txd && !$past(dataPending); endproperty
	a_d: assert property (p_d) else $error("drop");
	property p_c; flowControl && dataPending && $fell(clearToSendN)
		|=> !line_driver_enable [*2] ##[1:3] line_driver_enable; endproperty
	a_c: assert property (p_c) else $error("cts");
	property p_l; $rose(line_driver_enable) |-> txd ##1 !txd [*2]; endproperty
	a_l: assert property (p_l) else $error("lead");
	property p_r; !flowControl && dataPending && !line_driver_enable |=> line_driver_enable; endproperty
	a_r: assert property (p_r) else $error("write did not raise enable");
	property p_b; busy == line_driver_enable; endproperty
	a_b: assert property (p_b) else $error("busy differs from enable");
	property p_i; !line_driver_enable |-> txd; endproperty
	a_i: assert property (p_i) else $error("txd not idle while enable low");
	c_c: cover property (line_driver_enable && dataPending);
	c_f: cover property (flowControl && line_driver_enable);
	c_e: cover property ($fell(line_driver_enable));
endmodule
`default_nettype wire

// ==== sim/line_station.sv ====
// Remote station decoding txd characters
`timescale 1ns/1ns
`default_nettype none
module line_station(
	input wire logic clock,
	input wire logic txd,
	input wire logic [15:0] divisor,
	output logic [7:0] rxByte,
	output logic rxValid
);
	initial forever begin
		rxValid = 0;
		@(negedge txd);
		repeat (divisor / 2) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (divisor) @(negedge clock);
			rxByte[i] = txd;
		end
		repeat (divisor) @(negedge clock);
		rxValid = txd;
		@(negedge clock);
	end
endmodule
`default_nettype wire

// ==== sim/uart_driver_enable_control_tb.sv ====
// Driver enable bench
`timescale 1ns/1ns
`default_nettype none
module uart_driver_enable_control_tb;
	logic clock = 0, reset = 1, flowControl = 0, twoStopBits = 0, clearToSendN = 1, dataWrite = 0;
	logic [15:0] divisor = 16'h0004;
	logic [7:0] writeData = 8'h00, rxByte, q[$];
	logic dataPending, line_driver_enable, txd, busy, rxValid;
	int err_count = 0, n_compared = 0, cycles = 0;
	initial forever #10 clock = ~clock;
	uart_driver_enable_control DUT(
		.clock(clock),
		.reset(reset),
		.divisor(divisor),
		.flowControl(flowControl),
		.twoStopBits(twoStopBits),
		.clearToSendN(clearToSendN),
		.dataWrite(dataWrite),
		.writeData(writeData),
		.dataPending(dataPending),
		.line_driver_enable(line_driver_enable),
		.txd(txd),
		.busy(busy)
	);
	line_station far(
		.clock(clock),
		.txd(txd),
		.divisor(divisor),
		.rxByte(rxByte),
		.rxValid(rxValid)
	);
	task checkFlag(input string what, input logic exp, got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	task compare(input string what, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task conclude;
		if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task send;
		@(posedge clock);
		dataWrite <= 1;
		writeData <= 8'($urandom);
		@(posedge clock);
		dataWrite <= 0;
		q.push_back(writeData);
	endtask
	always @(posedge rxValid) begin
		compare("rxByte", q.pop_front(), rxByte);
		checkFlag("enableInStop", 1'b1, line_driver_enable);
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		void'($urandom(32'h5e19f4d8));
		repeat (5) @(posedge clock);
		reset <= 0;
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			flowControl <= i > 3;
			twoStopBits <= i[0];
			send();
			if (i == 4) repeat (6) @(posedge clock);
			clearToSendN <= i < 4;
			repeat (i % 3) begin
				do @(negedge clock); while (dataPending !== 1'b0);
				send();
			end
			repeat (3) @(negedge clock);
			while (busy !== 1'b0) @(negedge clock);
			checkFlag("enableIdle", 1'b0, line_driver_enable);
			checkFlag("txdIdle", 1'b1, txd);
		end
		compare("left", 8'h00, 8'(q.size()));
		checkFlag("pending", 1'b0, dataPending);
		conclude();
	end
endmodule
bind uart_driver_enable_control uart_de_monitor mon(
	.clock(clock),
	.reset(reset),
	.flowControl(flowControl),
	.clearToSendN(clearToSendN),
	.dataPending(dataPending),
	.line_driver_enable(line_driver_enable),
	.txd(txd),
	.busy(busy)
);
`default_nettype wire
